//--- rtl/nicm_defines.svh
`ifndef NICM_DEFINES_SVH
`define NICM_DEFINES_SVH

`define NICM_W 32
`define NICM_AW 64
`define NICM_MW 32
`define NICM_CAUSE_RST 32'h0000_0000
`define NICM_MASK_RST 32'h0000_0000
`define NICM_ZERO 32'h0000_0000
`define NICM_SEL_CAUSE 1'h0
`define NICM_SEL_MASK 1'h1
`define NICM_ADDR_RST 64'h0000_0000_0000_0000

`endif

//--- rtl/nicm_pkg.sv
`include "nicm_defines.svh"

package nicm_pkg;

    typedef logic [`NICM_W-1:0] nicm_bits_t;
    typedef logic [`NICM_AW-1:0] nicm_addr_t;
    typedef logic [`NICM_MW-1:0] nicm_data_t;

    typedef enum logic [2:0] {
        NICM_MSG_IDLE = 3'h1,
        NICM_MSG_REQ = 3'h2,
        NICM_MSG_GAP = 3'h4
    } nicm_msg_state_t;

endpackage

//--- rtl/nicm_msg_if.sv
`timescale 1ns/100ps

interface nicm_msg_if;
    import nicm_pkg::*;

    logic fire;
    nicm_addr_t addr;
    nicm_data_t data;

    modport core (output fire, output addr, output data);
    modport msg (input fire, input addr, input data);
endinterface

//--- rtl/nicm_msg.sv
`timescale 1ns/100ps
`include "nicm_defines.svh"

// message-signalled write engine: one write per fire, fires arriving while busy merge into one pending write, held until accepted
module nicm_msg
    import nicm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    nicm_msg_if.msg link,
    input wire logic msg_ack,
    output logic msg_req,
    output nicm_addr_t msg_addr,
    output nicm_data_t msg_data
);

    nicm_msg_state_t state;
    nicm_msg_state_t next_state;
    logic owed;
    logic next_owed;
    logic next_msg_req;
    nicm_addr_t next_msg_addr;
    nicm_data_t next_msg_data;

    always_comb begin
        next_state = state;
        next_owed = owed | link.fire;
        next_msg_req = msg_req;
        next_msg_addr = msg_addr;
        next_msg_data = msg_data;
        case (state)
            NICM_MSG_IDLE: begin
                if (next_owed) begin
                    next_state = NICM_MSG_REQ;
                    next_owed = 1'h0;
                    next_msg_req = 1'h1;
                    next_msg_addr = link.addr;
                    next_msg_data = link.data;
                end
            end
            NICM_MSG_REQ: begin
                if (msg_ack) begin
                    next_state = NICM_MSG_GAP;
                    next_msg_req = 1'h0;
                end
            end
            NICM_MSG_GAP: begin
                next_state = NICM_MSG_IDLE;
            end
            default: begin
                next_state = NICM_MSG_IDLE;
                next_msg_req = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= NICM_MSG_IDLE;
            owed <= 1'h0;
            msg_req <= 1'h0;
            msg_addr <= `NICM_ADDR_RST;
            msg_data <= `NICM_ZERO;
        end else begin
            state <= next_state;
            owed <= next_owed;
            msg_req <= next_msg_req;
            msg_addr <= next_msg_addr;
            msg_data <= next_msg_data;
        end
    end

endmodule

//--- rtl/nicm_intr.sv
`timescale 1ns/100ps
`include "nicm_defines.svh"

module nicm_intr
    import nicm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`NICM_W-1:0] hw_event,
    input wire logic cause_set_wr,
    input wire logic [`NICM_W-1:0] cause_set_data,
    input wire logic mask_set_wr,
    input wire logic [`NICM_W-1:0] mask_set_data,
    input wire logic mask_clr_wr,
    input wire logic [`NICM_W-1:0] mask_clr_data,
    input wire logic rd_req,
    input wire logic rd_sel,
    output logic rd_valid,
    output logic [`NICM_W-1:0] rd_data,
    output logic irq,
    input wire logic msg_en,
    input wire logic [`NICM_AW-1:0] msg_cfg_addr,
    input wire logic [`NICM_MW-1:0] msg_cfg_data,
    input wire logic msg_ack,
    output logic msg_req,
    output logic [`NICM_AW-1:0] msg_addr,
    output logic [`NICM_MW-1:0] msg_data
);

    // merge set and clear vectors; clear wins where both name a bit
    function automatic nicm_bits_t merge_bits(
        input nicm_bits_t cur,
        input nicm_bits_t set_v,
        input nicm_bits_t clr_v
    );
        merge_bits = (cur & ~clr_v) | (set_v & ~clr_v);
    endfunction

    // gate a write vector by its strobe
    function automatic nicm_bits_t gate(
        input logic en,
        input nicm_bits_t v
    );
        gate = en ? v : `NICM_ZERO;
    endfunction

    nicm_bits_t cause;
    nicm_bits_t next_cause;
    nicm_bits_t mask;
    nicm_bits_t next_mask;
    nicm_bits_t armed;
    nicm_bits_t next_armed;
    nicm_bits_t incoming;
    nicm_bits_t cause_clr;
    logic cause_rd;
    logic mask_rd;

    logic next_rd_valid;
    nicm_bits_t next_rd_data;
    logic next_irq;
    logic msg_fire;
    logic next_msg_fire;

    nicm_msg_if msg_link ();

    assign cause_rd = rd_req & (rd_sel == `NICM_SEL_CAUSE);
    assign mask_rd = rd_req & (rd_sel == `NICM_SEL_MASK);

    // cause register: single view of every source
    always_comb begin
        incoming = hw_event | gate(cause_set_wr, cause_set_data);
        cause_clr = gate(cause_rd, cause);
        // new arrivals re-set after the clear term
        next_cause = merge_bits(cause, `NICM_ZERO, cause_clr)
            | incoming;
        // recorded regardless of the mask
        if (!rst_n) begin
            next_cause = `NICM_CAUSE_RST;
        end
    end

    always_ff @(posedge clk) begin
        cause <= next_cause;
    end

    // mask register: set and clear ports, no read-modify-write
    always_comb begin
        next_mask = merge_bits(mask,
            gate(mask_set_wr, mask_set_data),
            gate(mask_clr_wr, mask_clr_data));
        if (!rst_n) begin
            next_mask = `NICM_MASK_RST;
        end
    end

    always_ff @(posedge clk) begin
        mask <= next_mask;
    end

    // read port: one cycle after the request
    always_comb begin
        next_rd_valid = rd_req;
        next_rd_data = rd_data;
        if (cause_rd) begin
            next_rd_data = cause;
        end else if (mask_rd) begin
            next_rd_data = mask;
        end
        if (!rst_n) begin
            next_rd_valid = 1'h0;
            next_rd_data = `NICM_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        rd_valid <= next_rd_valid;
        rd_data <= next_rd_data;
    end

    // interrupt wire, quiet while message delivery is in use
    always_comb begin
        next_irq = (|(next_cause & next_mask)) & ~msg_en;
        if (!rst_n) begin
            next_irq = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        irq <= next_irq;
    end

    // message trigger: one fire per cycle in which any unmasked bit newly becomes pending; fires while a message is busy merge into one
    always_comb begin
        next_armed = cause & mask;
        next_msg_fire = msg_en & (|(cause & mask & ~armed));
        if (!rst_n) begin
            next_armed = `NICM_ZERO;
            next_msg_fire = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        armed <= next_armed;
        msg_fire <= next_msg_fire;
    end

    assign msg_link.fire = msg_fire;
    assign msg_link.addr = msg_cfg_addr;
    assign msg_link.data = msg_cfg_data;

    nicm_msg u_msg (
        .clk(clk),
        .rst_n(rst_n),
        .link(msg_link.msg),
        .msg_ack(msg_ack),
        .msg_req(msg_req),
        .msg_addr(msg_addr),
        .msg_data(msg_data)
    );

endmodule

//--- verification/nicm_intr_sva.sv
`timescale 1ns/100ps

module nicm_intr_sva
    import nicm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire nicm_bits_t hw_event,
    input wire logic cause_set_wr,
    input wire nicm_bits_t cause_set_data,
    input wire logic mask_set_wr,
    input wire nicm_bits_t mask_set_data,
    input wire logic mask_clr_wr,
    input wire nicm_bits_t mask_clr_data,
    input wire logic rd_req,
    input wire logic rd_sel,
    input wire logic rd_valid,
    input wire nicm_bits_t rd_data,
    input wire logic irq,
    input wire logic msg_en,
    input wire logic msg_ack,
    input wire logic msg_req,
    input wire nicm_data_t msg_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence crd;
        rd_req && !rd_sel;
    endsequence
    sequence mrd;
        rd_req && rd_sel && !mask_set_wr && !mask_clr_wr;
    endsequence
    read_answer_a: assert property (
        rd_req |=> rd_valid) else $error("read not answered");
    read_clears_a: assert property (
        (crd ##0 hw_event == 32'h0 && !cause_set_wr) ##1 crd
        |=> rd_data == 32'h0) else $error("cause not cleared");
    event_kept_a: assert property (
        crd ##1 crd |=> (rd_data & $past(hw_event, 2)) == $past(hw_event, 2))
        else $error("event lost");
    mask_read_a: assert property (
        mrd ##1 mrd |=> $stable(rd_data)) else $error("mask changed");
    clear_quiet_a: assert property (
        mask_clr_wr && mask_clr_data == 32'hFFFF_FFFF |=> !irq)
        else $error("irq while masked");
    post_raise_a: assert property (
        cause_set_wr && cause_set_data != 32'h0 && mask_set_wr && !msg_en
        && mask_set_data == 32'hFFFF_FFFF && !mask_clr_wr |=> irq)
        else $error("posted cause no irq");
    msg_hold_a: assert property (
        msg_req && !msg_ack |=> msg_req && $stable(msg_data))
        else $error("message dropped");
    msg_gap_a: assert property (
        msg_req && msg_ack |=> !msg_req) else $error("message not ended");
endmodule

bind nicm_intr nicm_intr_sva u_sva (
    .clk(clk),
    .rst_n(rst_n),
    .hw_event(hw_event),
    .cause_set_wr(cause_set_wr),
    .cause_set_data(cause_set_data),
    .mask_set_wr(mask_set_wr),
    .mask_set_data(mask_set_data),
    .mask_clr_wr(mask_clr_wr),
    .mask_clr_data(mask_clr_data),
    .rd_req(rd_req),
    .rd_sel(rd_sel),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .irq(irq),
    .msg_en(msg_en),
    .msg_ack(msg_ack),
    .msg_req(msg_req),
    .msg_data(msg_data)
);

//--- verification/nicm_host_model.sv
`timescale 1ns/100ps

// bus side: accepts messages promptly or after a random stall
module nicm_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic msg_req,
    output logic msg_ack
);
    integer seed = 25659;
    logic go;
    initial msg_ack = 1'h0;
    always @(posedge clk) begin
        go = {$random(seed)} % 3 == 0;
        #1 msg_ack = rst_n && msg_req && go;
    end
endmodule

//--- verification/nic_interrupt_cause_mask_test.sv
`timescale 1ns/100ps

module nic_interrupt_cause_mask_test
    import nicm_pkg::*;
;
    logic clk = 1'h0, rst_n = 1'h0, rd_req = 1'h0, rd_sel = 1'h0;
    logic msg_en = 1'h0, cause_set_wr = 1'h0;
    logic mask_set_wr = 1'h0, mask_clr_wr = 1'h0;
    nicm_bits_t hw_event = 32'h0, cause_set_data = 32'h0;
    nicm_bits_t mask_set_data = 32'h0, mask_clr_data = 32'h0;
    nicm_addr_t msg_cfg_addr = 64'h0000_0040_FEE0_1000;
    nicm_data_t msg_cfg_data = 32'h0000_4321;
    logic rd_valid, irq, msg_ack, msg_req, exp_rv, exp_irq;
    nicm_bits_t rd_data, cause, mask, exp_rd;
    nicm_addr_t msg_addr;
    nicm_data_t msg_data;
    integer seed = 25659, miscompares = 0, checks = 0, n_msg = 0;
    nicm_intr u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .hw_event(hw_event),
        .cause_set_wr(cause_set_wr),
        .cause_set_data(cause_set_data),
        .mask_set_wr(mask_set_wr),
        .mask_set_data(mask_set_data),
        .mask_clr_wr(mask_clr_wr),
        .mask_clr_data(mask_clr_data),
        .rd_req(rd_req),
        .rd_sel(rd_sel),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .irq(irq),
        .msg_en(msg_en),
        .msg_cfg_addr(msg_cfg_addr),
        .msg_cfg_data(msg_cfg_data),
        .msg_ack(msg_ack),
        .msg_req(msg_req),
        .msg_addr(msg_addr),
        .msg_data(msg_data)
    );
    nicm_host_model u_host (
        .clk(clk),
        .rst_n(rst_n),
        .msg_req(msg_req),
        .msg_ack(msg_ack)
    );
    initial forever #2.5 clk = ~clk;
    task chk(string what, logic [63:0] e, logic [63:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // all ones every 16th step, sparse random otherwise
    function nicm_bits_t pick(int i);
        return i % 16 == 0 ? 32'hFFFF_FFFF : $random(seed) & $random(seed);
    endfunction
    function nicm_bits_t next_cause(nicm_bits_t c);
        return (rd_req && !rd_sel ? 32'h0 : c) | hw_event
            | (cause_set_wr ? cause_set_data : 32'h0);
    endfunction
    function nicm_bits_t next_mask(nicm_bits_t m);
        return (m | (mask_set_wr ? mask_set_data : 32'h0))
            & ~(mask_clr_wr ? mask_clr_data : 32'h0);
    endfunction
    initial begin
        cause = 32'h0;
        mask = 32'h0;
        exp_rd = 32'h0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'h1;
        chk("irq", 64'h0, irq);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            exp_rv = rd_req;
            if (rd_req) exp_rd = rd_sel ? mask : cause;
            cause = next_cause(cause);
            mask = next_mask(mask);
            // mid-run reset pulse wipes all state
            if (!rst_n) begin
                exp_rv = 1'h0;
                exp_rd = 32'h0;
                cause = 32'h0;
                mask = 32'h0;
            end
            exp_irq = |(cause & mask) && !msg_en;
            #1;
            chk("irq", exp_irq, irq);
            chk("rd_valid", exp_rv, rd_valid);
            chk("rd_data", exp_rd, rd_data);
            if (i < 2002) chk("msg_idle", 64'h0, msg_req);
            if (msg_req) chk("msg_addr", msg_cfg_addr, msg_addr);
            if (msg_req) chk("msg_data", msg_cfg_data, msg_data);
            n_msg += msg_req;
            msg_en = i > 2000;
            rst_n = i != 1000;
            rd_req = 1'($random(seed));
            rd_sel = 1'($random(seed));
            cause_set_wr = 1'($random(seed));
            mask_set_wr = 1'($random(seed));
            mask_clr_wr = 1'($random(seed));
            hw_event = pick(i + 1) & pick(i + 2);
            cause_set_data = pick(i + 4);
            mask_set_data = pick(i + 8);
            mask_clr_data = pick(i);
        end
        chk("msg_seen", 64'h1, {63'h0, n_msg > 0});
        report_and_stop;
    end
endmodule
